// *** shared/silk_pkg.sv ***
// Purpose: constants for the status and interrupt block
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes: offsets are byte addresses
package silk_pkg;
	localparam logic [7:0] SILK_OFS_STATUS = 8'h00;
	localparam logic [7:0] SILK_OFS_STICKY = 8'h04;
	localparam logic [7:0] SILK_OFS_IRQEN = 8'h08;
	localparam logic [7:0] SILK_OFS_CTRL = 8'h0C;
	localparam logic [7:0] SILK_OFS_DELAY = 8'h10;
	localparam logic [7:0] SILK_OFS_OUTEN = 8'h14;
	localparam int SILK_NCOND = 8;
	// Condition bit positions
	localparam int SILK_POS_IN0 = 0;
	localparam int SILK_POS_VLOCK = 4;
	localparam int SILK_POS_FLOCK = 5;
	localparam int SILK_POS_NHOLD = 6;
	localparam int SILK_POS_REF = 7;
	localparam int SILK_POS_VCOCAL = 8;
	localparam int SILK_POS_SEL = 9;
	// Control bit positions
	localparam int SILK_POS_VCXO_PLL_BYPASS = 0;
	localparam int SILK_POS_SYNTH_PLL_BYPASS = 1;
	localparam int SILK_POS_SRG = 2;
	localparam int SILK_POS_MODE = 3;
	localparam int SILK_POS_FVCV = 5;
	// Delay field positions
	localparam int SILK_POS_DCLK = 0;
	localparam int SILK_POS_DREF = 8;
	localparam int SILK_POS_DFINE = 11;
	localparam int SILK_POS_DGLB = 16;
	// Reset values
	localparam logic [7:0] SILK_RST_IRQEN = 8'h00;
	localparam logic [31:0] SILK_RST_CTRL = 32'h0000_0020;
	localparam logic [31:0] SILK_RST_DELAY = 32'h0000_0000;
	localparam logic [31:0] SILK_RST_OUTEN = 32'h0000_0000;
	// Recommended alignment settings for software
	localparam logic [7:0] SILK_REC_DCLK = 8'h00;
	localparam logic [2:0] SILK_REC_DREF = 3'h1;
	localparam logic [2:0] SILK_REC_DFINE = 3'h1;
	localparam logic [7:0] SILK_REC_DGLB = 8'h29;
	localparam logic [7:0] SILK_VTUNE_MID = 8'h80;
	typedef enum logic [1:0] {
		SILK_MODE_MANUAL,
		SILK_MODE_SHORT_HOLD,
		SILK_MODE_AUTO_HOLD,
		SILK_MODE_AUTO
	} silk_mode_e;
endpackage

// *** hw/silk_status_irq.sv ***
// Purpose: status, sticky fault bits, interrupt and lock-detect logic
// Assumes: condition inputs are asynchronous, one 20 MHz clock
// Notes: registers reached over AHB-Lite
//
// Notes on behaviour
// - momentary bits read live, no history
// - sticky bit sets on event, write-one clears
// - still-present fault sets sticky bit again
// - per-condition enable masks interrupt
// - interrupt holds while any enabled sticky set
// - eight sticky conditions; calibration, selection momentary
// - two-bit code gives selected input
// - reference-valid depends on switching mode
// - lock-detect high only when both locked
// - vcxo bypass excludes vcxo lock
// - deterministic delay flag for VCXO PLL in use with synth PLL bypassed
// - reset loads defaults, tune voltage mid
// - outputs disabled after startup
// - delays ignore sysref trigger source
// - coarse one or more with clock delay zero puts sysref ahead, fine ignored
// - recommended settings align coincident edges
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
module silk_status_irq
	import silk_pkg::*;
#(
	parameter int NIN = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [NIN-1:0] input_active_pin,
	input wire logic vcxo_pll_locked_pin,
	input wire logic synth_pll_locked_pin,
	input wire logic holdover_pin,
	input wire logic vco_cal_busy_pin,
	input wire logic [1:0] selected_input_pin,
	output logic irq_out_n,
	output logic lock_detect,
	output logic deterministic_delay,
	output logic sysref_leads_clock,
	output logic [7:0] vcxo_tune_voltage_pin,
	output logic [7:0] clock_output_en,
	output logic [7:0] sysref_output_en,
	output logic [7:0] clock_delay,
	output logic [2:0] sysref_coarse_delay,
	output logic [2:0] sysref_fine_delay,
	output logic [7:0] sysref_global_delay
);

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	localparam int NRAW = NIN + 6;
	logic [NRAW-1:0] raw;
	logic [NRAW-1:0] sync1_reg;
	logic [NRAW-1:0] sync2_reg;
	assign raw = {selected_input_pin, vco_cal_busy_pin, holdover_pin,
		synth_pll_locked_pin, vcxo_pll_locked_pin, input_active_pin};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
		end
	end

	logic [NIN-1:0] input_active_now;
	logic vcxo_pll_locked_now;
	logic synth_pll_locked_now;
	logic not_holdover_now;
	logic vco_cal_state;
	logic [1:0] selected_input_code;
	logic reference_valid_now;
	assign input_active_now = sync2_reg[NIN-1:0];
	assign vcxo_pll_locked_now = sync2_reg[NIN];
	assign synth_pll_locked_now = sync2_reg[NIN+1];
	assign not_holdover_now = ~sync2_reg[NIN+2];
	assign vco_cal_state = sync2_reg[NIN+3];
	assign selected_input_code = sync2_reg[NIN+5:NIN+4];

	////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] irq_en_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] delay_reg;
	logic [31:0] outen_reg;
	logic [SILK_NCOND-1:0] sticky_reg;
	silk_mode_e mode;
	assign mode = silk_mode_e'(ctrl_reg[SILK_POS_MODE +: 2]);

	always_comb begin
		case (mode)
			SILK_MODE_MANUAL, SILK_MODE_SHORT_HOLD: begin
				reference_valid_now = input_active_now[selected_input_code];
			end
			SILK_MODE_AUTO_HOLD: begin
				reference_valid_now = (|input_active_now) &&
					(input_active_now[selected_input_code] || not_holdover_now);
			end
			default: begin
				reference_valid_now = |input_active_now;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states
	logic wr_pend_reg;
	logic [7:0] addr_reg;
	logic take;
	assign take = hsel && htrans[1] && hready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= take && hwrite;
			if (take) begin
				addr_reg <= haddr[7:0];
			end
		end
	end

	logic wr_sticky;
	logic wr_irqen;
	logic wr_ctrl;
	logic wr_delay;
	logic wr_outen;
	always_comb begin
		wr_sticky = 1'b0;
		wr_irqen = 1'b0;
		wr_ctrl = 1'b0;
		wr_delay = 1'b0;
		wr_outen = 1'b0;
		if (!wr_pend_reg) begin
			wr_sticky = 1'b0;
		end else if (addr_reg == SILK_OFS_STICKY) begin
			wr_sticky = 1'b1;
		end else if (addr_reg == SILK_OFS_IRQEN) begin
			wr_irqen = 1'b1;
		end else if (addr_reg == SILK_OFS_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (addr_reg == SILK_OFS_DELAY) begin
			wr_delay = 1'b1;
		end else if (addr_reg == SILK_OFS_OUTEN) begin
			wr_outen = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_reg <= SILK_RST_IRQEN;
			ctrl_reg <= SILK_RST_CTRL;
			delay_reg <= SILK_RST_DELAY;
		end else begin
			if (wr_irqen) begin
				irq_en_reg <= hwdata[7:0];
			end
			if (wr_ctrl) begin
				ctrl_reg <= {26'h0, hwdata[5:0]};
			end
			if (wr_delay) begin
				delay_reg <= {8'h00, hwdata[23:16], 2'h0, hwdata[13:0]};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outen_reg <= SILK_RST_OUTEN;
		end else if (wr_outen) begin
			outen_reg <= {16'h0000, hwdata[15:0]};
		end
	end

	////////////////////////////////////////////////////////////////
	// Sticky condition bits
	logic [SILK_NCOND-1:0] cond_now;
	logic [SILK_NCOND-1:0] cond_prev_reg;
	logic [SILK_NCOND-1:0] cond_event;
	logic [SILK_NCOND-1:0] clr_mask;
	assign cond_now = {reference_valid_now, not_holdover_now, synth_pll_locked_now,
		vcxo_pll_locked_now, input_active_now};
	assign clr_mask = wr_sticky ? hwdata[SILK_NCOND-1:0] : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_prev_reg <= '1;
		end else begin
			cond_prev_reg <= cond_now;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < SILK_NCOND; gi++) begin : g_sticky
			assign cond_event[gi] = ~cond_now[gi] | (cond_prev_reg[gi] ^ cond_now[gi]);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					sticky_reg[gi] <= 1'b0;
				end else if (cond_event[gi]) begin
					sticky_reg[gi] <= 1'b1;
				end else if (clr_mask[gi]) begin
					sticky_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Interrupt and lock outputs
	// enable mask
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= ~|(sticky_reg & irq_en_reg);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_detect <= 1'b0;
		end else begin
			lock_detect <= synth_pll_locked_now &&
				(vcxo_pll_locked_now || ctrl_reg[SILK_POS_VCXO_PLL_BYPASS]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			deterministic_delay <= 1'b0;
		end else begin
			deterministic_delay <= !ctrl_reg[SILK_POS_VCXO_PLL_BYPASS] && ctrl_reg[SILK_POS_SYNTH_PLL_BYPASS];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vcxo_tune_voltage_pin <= SILK_VTUNE_MID;
		end else if (ctrl_reg[SILK_POS_FVCV]) begin
			vcxo_tune_voltage_pin <= SILK_VTUNE_MID;
		end else begin
			vcxo_tune_voltage_pin <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Delay and enable outputs
	// delays ignore trigger source
	assign clock_delay = delay_reg[SILK_POS_DCLK +: 8];
	assign sysref_coarse_delay = delay_reg[SILK_POS_DREF +: 3];
	assign sysref_fine_delay = delay_reg[SILK_POS_DFINE +: 3];
	assign sysref_global_delay = delay_reg[SILK_POS_DGLB +: 8];
	assign clock_output_en = outen_reg[7:0];
	assign sysref_output_en = outen_reg[15:8];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sysref_leads_clock <= 1'b0;
		end else begin
			sysref_leads_clock <= (sysref_coarse_delay >= SILK_REC_DREF) &&
				(clock_delay == SILK_REC_DCLK);
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data
	logic [31:0] rd_next;
	always_comb begin
		rd_next = 32'h0000_0000;
		if (!take || hwrite) begin
			rd_next = 32'h0000_0000;
		end else if (haddr[7:0] == SILK_OFS_STATUS) begin
			rd_next[SILK_NCOND-1:0] = cond_now;
			rd_next[SILK_POS_VCOCAL] = vco_cal_state;
			rd_next[SILK_POS_SEL +: 2] = selected_input_code;
		end else if (haddr[7:0] == SILK_OFS_STICKY) begin
			rd_next[SILK_NCOND-1:0] = sticky_reg;
		end else if (haddr[7:0] == SILK_OFS_IRQEN) begin
			rd_next[7:0] = irq_en_reg;
		end else if (haddr[7:0] == SILK_OFS_CTRL) begin
			rd_next = ctrl_reg;
		end else if (haddr[7:0] == SILK_OFS_DELAY) begin
			rd_next = delay_reg;
		end else if (haddr[7:0] == SILK_OFS_OUTEN) begin
			rd_next = outen_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= rd_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

endmodule

// *** test/silk_status_irq_sva.sv ***
// Purpose: checker for the status and interrupt block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module ports
`timescale 1ns/1ns
module silk_status_irq_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic vcxo_pll_locked_pin,
	input wire logic synth_pll_locked_pin,
	input wire logic lock_detect,
	input wire logic deterministic_delay,
	input wire logic sysref_leads_clock,
	input wire logic [7:0] vcxo_tune_voltage_pin,
	input wire logic [7:0] clock_output_en,
	input wire logic [7:0] clock_delay,
	input wire logic [2:0] sysref_coarse_delay
);
	logic wr_d1;
	logic wr_d2;
	logic wr_d3;
	logic lead_d1;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_d1 <= 1'b0;
			wr_d2 <= 1'b0;
			wr_d3 <= 1'b0;
			lead_d1 <= 1'b0;
		end else begin
			wr_d1 <= hsel && htrans[1] && hready && hwrite;
			wr_d2 <= wr_d1;
			wr_d3 <= wr_d2;
			lead_d1 <= sysref_coarse_delay != 3'h0 && clock_delay == 8'h00;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////
	sequence s_both_locked;
		(vcxo_pll_locked_pin && synth_pll_locked_pin) [*4];
	endsequence
	sequence s_synth_lost;
		(!synth_pll_locked_pin) [*4];
	endsequence
	sequence s_vcxo_lost_kept;
		(!vcxo_pll_locked_pin && deterministic_delay) [*4];
	endsequence
	property p_lock_on;
		s_both_locked |-> lock_detect;
	endproperty
	property p_synth_off;
		s_synth_lost |-> !lock_detect;
	endproperty
	property p_vcxo_off;
		s_vcxo_lost_kept |-> !lock_detect;
	endproperty
	property p_tune;
		vcxo_tune_voltage_pin == 8'h80 || vcxo_tune_voltage_pin == 8'h00;
	endproperty
	property p_lead;
		sysref_leads_clock == lead_d1;
	endproperty
	property p_det;
		$changed(deterministic_delay) |-> wr_d3;
	endproperty
	property p_outen;
		$changed(clock_output_en) |-> wr_d2;
	endproperty
	property p_delay;
		$changed(clock_delay) || $changed(sysref_coarse_delay) |-> wr_d2;
	endproperty
	a_lock_on: assert property (p_lock_on) else $error("lock low with both locked");
	a_synth_off: assert property (p_synth_off) else $error("lock high, synth lost");
	a_vcxo_off: assert property (p_vcxo_off) else $error("lock high, vcxo lost");
	a_tune: assert property (p_tune) else $error("tune value bad");
	a_lead: assert property (p_lead) else $error("sysref lead flag wrong");
	a_det: assert property (p_det) else $error("delay flag moved unasked");
	a_outen: assert property (p_outen) else $error("output enable moved unasked");
	a_delay: assert property (p_delay) else $error("delay moved unasked");
endmodule
bind silk_status_irq silk_status_irq_chk u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.vcxo_pll_locked_pin(vcxo_pll_locked_pin), .synth_pll_locked_pin(synth_pll_locked_pin),
	.lock_detect(lock_detect), .deterministic_delay(deterministic_delay),
	.sysref_leads_clock(sysref_leads_clock), .vcxo_tune_voltage_pin(vcxo_tune_voltage_pin),
	.clock_output_en(clock_output_en), .clock_delay(clock_delay),
	.sysref_coarse_delay(sysref_coarse_delay));

// *** test/silk_cond_src.sv ***
// Purpose: condition pin source on the device side
// Assumes: command order {sel, cal, hold, synth, vcxo, inputs}
// Notes: pins change just after a clock edge
`timescale 1ns/1ns
module silk_cond_src (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] cond_cmd,
	output logic [3:0] input_active_pin,
	output logic vcxo_pll_locked_pin,
	output logic synth_pll_locked_pin,
	output logic holdover_pin,
	output logic vco_cal_busy_pin,
	output logic [1:0] selected_input_pin
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{selected_input_pin, vco_cal_busy_pin, holdover_pin} <= 4'h0;
			{synth_pll_locked_pin, vcxo_pll_locked_pin, input_active_pin} <= 6'h3F;
		end else begin
			{selected_input_pin, vco_cal_busy_pin, holdover_pin} <= cond_cmd[9:6];
			{synth_pll_locked_pin, vcxo_pll_locked_pin, input_active_pin} <= cond_cmd[5:0];
		end
	end
endmodule

// *** test/silk_status_irq_tb.sv ***
// Purpose: self-checking bench for the status and interrupt block
// Assumes: single AHB-Lite master, one slave
// Notes: manual switching mode unless set otherwise
`timescale 1ns/1ns
module silk_status_irq_tb
	import silk_pkg::*;
;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, vl, fl, hold, cal;
	logic irq_out_n, lock_detect, det, leads;
	logic [1:0] htrans, sel;
	logic [3:0] act;
	logic [9:0] cond_cmd;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] tune, clk_en, ref_en, dclk, dglb;
	logic [2:0] dref, dfine;
	int fail_count;
	int cmp_count;
	silk_cond_src u_src (.clk(clk), .rst_n(rst_n), .cond_cmd(cond_cmd),
		.input_active_pin(act), .vcxo_pll_locked_pin(vl), .synth_pll_locked_pin(fl),
		.holdover_pin(hold), .vco_cal_busy_pin(cal), .selected_input_pin(sel));
	silk_status_irq DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .input_active_pin(act),
		.vcxo_pll_locked_pin(vl), .synth_pll_locked_pin(fl), .holdover_pin(hold),
		.vco_cal_busy_pin(cal), .selected_input_pin(sel), .irq_out_n(irq_out_n),
		.lock_detect(lock_detect), .deterministic_delay(det), .sysref_leads_clock(leads),
		.vcxo_tune_voltage_pin(tune), .clock_output_en(clk_en), .sysref_output_en(ref_en),
		.clock_delay(dclk), .sysref_coarse_delay(dref), .sysref_fine_delay(dfine),
		.sysref_global_delay(dglb));
	////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			fail_count++;
			results();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	function automatic logic [31:0] exp_st(input logic [9:0] c);
		return {21'h0, c[9:7], c[c[9:8]], ~c[6], c[5:0]};
	endfunction
	task automatic settle(input logic [9:0] c);
		cond_cmd <= c;
		repeat (6) @(posedge clk);
	endtask
	////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		cond_cmd = 10'h03F;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(SILK_OFS_CTRL, SILK_RST_CTRL);
		rdchk(SILK_OFS_OUTEN, SILK_RST_OUTEN);
		rdchk(SILK_OFS_IRQEN, 32'h0);
		chk({24'h0, tune}, {24'h0, SILK_VTUNE_MID});
		chk({16'h0, ref_en, clk_en}, 32'h0);
		chk({31'h0, irq_out_n}, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			settle({i[1:0], i[0], i[1], i[2], 1'b1, ~(4'h1 << (i % 4 + (i < 4 ? 1 : 0)))});
			rdchk(SILK_OFS_STATUS, exp_st(cond_cmd));
			chk({31'h0, lock_detect}, {31'h0, cond_cmd[5]});
		end
		settle(10'h03F);
		bus(1'b1, SILK_OFS_STICKY, 32'hFF);
		rdchk(SILK_OFS_STICKY, 32'h0);
		bus(1'b1, SILK_OFS_IRQEN, 32'h02);
		settle(10'h03D);
		rdchk(SILK_OFS_STICKY, 32'h02);
		chk({31'h0, irq_out_n}, 32'h0);
		bus(1'b1, SILK_OFS_STICKY, 32'h02);
		repeat (2) @(posedge clk);
		rdchk(SILK_OFS_STICKY, 32'h02);
		settle(10'h03F);
		bus(1'b1, SILK_OFS_STICKY, 32'hFF);
		repeat (3) @(posedge clk);
		chk({31'h0, irq_out_n}, 32'h1);
		settle(10'h03B);
		rdchk(SILK_OFS_STICKY, 32'h04);
		chk({31'h0, irq_out_n}, 32'h1);
		bus(1'b1, SILK_OFS_IRQEN, 32'h04);
		repeat (3) @(posedge clk);
		chk({31'h0, irq_out_n}, 32'h0);
		$display("test sticky done");
		settle(10'h02F);
		chk({31'h0, lock_detect}, 32'h0);
		bus(1'b1, SILK_OFS_CTRL, 32'h21);
		repeat (3) @(posedge clk);
		chk({30'h0, lock_detect, det}, 32'h2);
		bus(1'b1, SILK_OFS_CTRL, 32'h22);
		repeat (3) @(posedge clk);
		chk({30'h0, lock_detect, det}, 32'h1);
		bus(1'b1, SILK_OFS_CTRL, 32'h38);
		settle(10'h030);
		bus(1'b0, SILK_OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h0);
		settle(10'h034);
		bus(1'b0, SILK_OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h80);
		bus(1'b1, SILK_OFS_CTRL, 32'h30);
		settle(10'h07E);
		bus(1'b0, SILK_OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h0);
		settle(10'h03E);
		bus(1'b0, SILK_OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h80);
		settle(10'h030);
		bus(1'b0, SILK_OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h0);
		bus(1'b1, SILK_OFS_CTRL, 32'h28);
		settle(10'h03E);
		bus(1'b0, SILK_OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h0);
		settle(10'h03F);
		bus(1'b0, SILK_OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h80);
		settle(10'h03F);
		$display("test lock done");
		bus(1'b1, SILK_OFS_DELAY, {8'h0, SILK_REC_DGLB, 2'h0, SILK_REC_DFINE, SILK_REC_DREF, 8'h0});
		bus(1'b1, SILK_OFS_CTRL, 32'h26);
		repeat (2) @(posedge clk);
		chk({8'h0, dglb, 2'h0, dfine, dref, dclk}, 32'h0029_0900);
		chk({31'h0, leads}, 32'h1);
		bus(1'b1, SILK_OFS_DELAY, 32'h0000_0100);
		repeat (2) @(posedge clk);
		chk({31'h0, leads}, 32'h1);
		bus(1'b1, SILK_OFS_DELAY, 32'h0000_0101);
		repeat (2) @(posedge clk);
		chk({31'h0, leads}, 32'h0);
		bus(1'b1, SILK_OFS_DELAY, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk({31'h0, leads}, 32'h0);
		bus(1'b1, SILK_OFS_OUTEN, 32'hA55A);
		repeat (2) @(posedge clk);
		chk({16'h0, ref_en, clk_en}, 32'hA55A);
		rdchk(8'h40, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b1, SILK_OFS_STATUS, 32'h0);
		rdchk(SILK_OFS_STATUS, exp_st(cond_cmd));
		$display("test delay done");
		results();
	end
endmodule
